// file: src/bwt_timer.sv
// basic timer with watchdog reset and oscillator stabilization gating
// Functional notes
// RL1 - select field picks clock divided by 4096, 1024, 128 or 16.
// RL2 - watchdog is off only when bits 7..4 hold 1010b.
// RL3 - device reset clears control to zero: watchdog on, divide by 4096.
// RL4 - writing 1 to bit 1 clears the counter; 0 does nothing.
// RL5 - writing 1 to bit 0 clears both prescalers; 0 does nothing.
// RL6 - eight-bit counter is read-only at its own address.
// RL7 - with watchdog enabled, every counter overflow raises a system reset.
// RL8 - software must clear the counter regularly to avoid watchdog reset.
// RL9 - overflow event is the carry out of counter bit 7.
// RL10 - stop release by reset or interrupt restarts oscillator and stabilization.
// RL11 - stabilization runs at divide 4096 after reset, else selected rate.
// RL12 - stabilization ends on bit 4 overflow, then the CPU clock runs.
// RL13 - control register is eight bits, read/write, decoded at D3h.
// RL14 - counter steps once per tick, wraps silently when watchdog disabled.
`timescale 1ns/1ps
`include "bwt_regs.svh"
module bwt_timer #(
   parameter int DIV_W = 13
) (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       STOP_ENTER,
   input  wire logic       STOP_WAKE_INT,
   output logic      [7:0] REG_RDATA,
   output logic            OSC_ENABLE,
   output logic            CPU_CLK_EN,
   output logic            STAB_DONE,
   output logic            WDT_RESET,
   output logic            SHARED_DIV_CLR
);
   bwt_pkg::bwt_ctrl_t  ctrl;
   bwt_pkg::bwt_state_t state;
   logic [DIV_W-1:0]    div_cnt;
   logic [7:0]          count;
   logic [3:0]          rst_cnt;
   logic [DIV_W-1:0]    tick_div;
   logic                tick;
   logic                wr_ctrl;
   logic                wr_cnt_clr;
   logic                wr_div_clr;
   logic                wdt_on;
   logic                overflow;
   logic                stab_ovf;
   logic                stab_reset;
   logic                stopped;
   logic [7:0]          next_count;

   assign wr_ctrl    = REG_WR && (REG_ADDR == `BWT_CTRL_ADDR);
   // RL4 clear on one
   assign wr_cnt_clr = wr_ctrl && REG_WDATA[`BWT_CNT_CLR_BIT];
   // RL5 divider clear
   assign wr_div_clr = wr_ctrl && REG_WDATA[`BWT_DIV_CLR_BIT];
   // RL2 signature decode
   assign wdt_on     = ctrl.wdt_code != `BWT_WDT_OFF_CODE;

   // RL3 reset to zero
   // RL13 control register write
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         ctrl <= `BWT_CTRL_RESET;
      else if (wr_ctrl)
      begin
         ctrl          <= REG_WDATA;
         // clear bits act as strobes and read back as zero
         ctrl.cnt_clr  <= 1'b0;
         ctrl.div_clr  <= 1'b0;
      end
   end

   // RL1 prescaler select
   // RL11 reset uses 4096
   always_comb
   begin
      if (stab_reset)
         tick_div = DIV_W'(`BWT_DIV_4096);
      else
         case (ctrl.clk_sel)
            2'b00:   tick_div = DIV_W'(`BWT_DIV_4096);
            2'b01:   tick_div = DIV_W'(`BWT_DIV_1024);
            2'b10:   tick_div = DIV_W'(`BWT_DIV_128);
            default: tick_div = DIV_W'(`BWT_DIV_16);
         endcase
   end

   // free-running divider; taps keep all rates phase aligned like a ripple chain
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || wr_div_clr || stopped)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + DIV_W'(1);
   end
   assign tick = ((div_cnt & (tick_div - DIV_W'(1))) == (tick_div - DIV_W'(1))) && !stopped;

   // RL9 bit 7 carry
   assign overflow = tick && (count == 8'h_FF);
   // RL12 bit 4 carry
   assign stab_ovf = tick && (count[`BWT_STAB_BIT:0] == 5'h1F);

   // RL14 increment and wrap
   always_comb
   begin
      next_count = count;
      if (tick)
         next_count = count + 8'h01;
   end

   // RL6 counter only cleared, never written
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || wr_cnt_clr || stopped)
         count <= 8'h00;
      else
         count <= next_count;
   end

   // RL10 stop and release sequencing
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         state      <= bwt_pkg::BWT_STAB;
         stab_reset <= 1'b1;
         stopped    <= 1'b0;
         rst_cnt    <= 4'h0;
      end
      else
         case (state)
            bwt_pkg::BWT_RUN:
            begin
               // RL7 overflow resets system
               if (overflow && wdt_on)
               begin
                  state   <= bwt_pkg::BWT_RST;
                  rst_cnt <= `BWT_RST_PULSE;
               end
               else if (STOP_ENTER)
                  stopped <= 1'b1;
               else if (stopped && STOP_WAKE_INT)
               begin
                  // RL11 interrupt release
                  stopped    <= 1'b0;
                  stab_reset <= 1'b0;
                  state      <= bwt_pkg::BWT_STAB;
               end
            end
            bwt_pkg::BWT_STAB:
            begin
               // RL12 release cpu clock
               if (stab_ovf)
               begin
                  state      <= bwt_pkg::BWT_RUN;
                  // forced /4096 only spans the interval, else select field is dead
                  stab_reset <= 1'b0;
               end
            end
            bwt_pkg::BWT_RST:
            begin
               // pulse held a few cycles so the reset tree sees it
               if (rst_cnt == 4'h1)
                  state <= bwt_pkg::BWT_RUN;
               rst_cnt <= rst_cnt - 4'h1;
            end
            default:
               state <= bwt_pkg::BWT_STAB;
         endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         OSC_ENABLE     <= 1'b1;
         CPU_CLK_EN     <= 1'b0;
         STAB_DONE      <= 1'b0;
         WDT_RESET      <= 1'b0;
         SHARED_DIV_CLR <= 1'b0;
      end
      else
      begin
         OSC_ENABLE     <= !(STOP_ENTER || stopped) || STOP_WAKE_INT;
         CPU_CLK_EN     <= (state == bwt_pkg::BWT_RUN || stab_ovf) && !STOP_ENTER
                           && !stopped;
         STAB_DONE      <= (state == bwt_pkg::BWT_STAB) && stab_ovf;
         WDT_RESET      <= (state == bwt_pkg::BWT_RUN && overflow && wdt_on)
                           || (state == bwt_pkg::BWT_RST && rst_cnt != 4'h1);
         // RL5 shared prescaler clear
         SHARED_DIV_CLR <= wr_div_clr;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         REG_RDATA <= 8'h00;
      else if (REG_RD && REG_ADDR == `BWT_CTRL_ADDR)
         REG_RDATA <= ctrl;
      else if (REG_RD && REG_ADDR == `BWT_COUNT_ADDR)
         REG_RDATA <= count;
      else
         REG_RDATA <= 8'h00;
   end

   // RL7 overflow reset
   a_wdt_reset_fires: assert property (@(posedge CLK) disable iff (SYS_RST) // RL7
      (state == bwt_pkg::BWT_RUN && overflow && wdt_on) |=> WDT_RESET [*7])
      else $error("watchdog overflow did not drive reset");
   // RL2 disabled no reset
   a_wdt_off_quiet: assert property (@(posedge CLK) disable iff (SYS_RST) // RL2
      (state == bwt_pkg::BWT_RUN && ctrl.wdt_code == 4'hA) |=> !WDT_RESET || $past(WDT_RESET))
      else $error("reset while watchdog disabled");
   // RL4 counter clear
   a_count_clear: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
      wr_cnt_clr |=> count == 8'h00)
      else $error("counter not cleared");
   // RL5 divider clear
   a_div_clear: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
      wr_div_clr |=> div_cnt == '0 && SHARED_DIV_CLR)
      else $error("dividers not cleared");
   // RL3 reset value
   a_ctrl_reset: assert property (@(posedge CLK) // RL3
      SYS_RST |=> ctrl == 8'h00 && state == bwt_pkg::BWT_STAB)
      else $error("control not zero after reset");
   // RL1 tick rate
   a_tick_rate: assert property (@(posedge CLK) disable iff (SYS_RST || stopped) // RL1
      (tick && ctrl.clk_sel == 2'b11 && !stab_reset && !wr_div_clr) |=>
      !tick [*8])
      else $error("tick spacing wrong for divide 16");
   // RL12 stabilization end
   a_stab_end: assert property (@(posedge CLK) disable iff (SYS_RST) // RL12
      (state == bwt_pkg::BWT_STAB && stab_ovf) |=> STAB_DONE && CPU_CLK_EN)
      else $error("stabilization end not signalled");
   // RL12 clock gated
   a_cpu_gated: assert property (@(posedge CLK) disable iff (SYS_RST) // RL12
      ($past(state) == bwt_pkg::BWT_STAB && !$past(stab_ovf)) |-> !CPU_CLK_EN)
      else $error("cpu clock ran during stabilization");
   // RL14 increment
   a_count_step: assert property (@(posedge CLK) disable iff (SYS_RST) // RL14
      (tick && !wr_cnt_clr && !stopped) |=> count == $past(count) + 8'h01)
      else $error("counter did not step");
   // RL6 read-only count
   a_count_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL6
      (REG_RD && REG_ADDR == 8'hFD) |=> REG_RDATA == $past(count))
      else $error("count readback wrong");
   // RL14 silent wrap
   a_wrap_quiet: assert property (@(posedge CLK) disable iff (SYS_RST) // RL14
      (state == bwt_pkg::BWT_RUN && overflow && !wdt_on) |=> !WDT_RESET && count == 8'h00)
      else $error("disabled watchdog wrap misbehaved");
   // RL9 wrap to zero
   a_ovf_wrap: assert property (@(posedge CLK) disable iff (SYS_RST) // RL9
      overflow |=> count == 8'h00)
      else $error("counter did not wrap on overflow");
   // RL13 control write
   a_ctrl_write: assert property (@(posedge CLK) disable iff (SYS_RST) // RL13
      wr_ctrl |=> ctrl == {$past(REG_WDATA[7:2]), 2'b00})
      else $error("control write not stored");
   // RL13 control read
   a_ctrl_read: assert property (@(posedge CLK) disable iff (SYS_RST) // RL13
      (REG_RD && REG_ADDR == 8'hD3) |=> REG_RDATA == $past(ctrl))
      else $error("control readback wrong");
   // RL4 strobes read zero
   a_strobe_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // RL4
      !ctrl.cnt_clr && !ctrl.div_clr)
      else $error("clear strobe bit held in control");
   // RL11 reset rate
   a_stab_rate: assert property (@(posedge CLK) disable iff (SYS_RST) // RL11
      (tick && stab_reset) |-> div_cnt[11:0] == 12'h_0FFF)
      else $error("stabilization after reset not at divide 4096");
   // RL1 divide 4096
   a_rate_4096: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
      (tick && !stab_reset && ctrl.clk_sel == 2'b00) |-> div_cnt[11:0] == 12'h_0FFF)
      else $error("tick off divide 4096 phase");
   // RL1 divide 1024
   a_rate_1024: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
      (tick && !stab_reset && ctrl.clk_sel == 2'b01) |-> div_cnt[9:0] == 10'h_03FF)
      else $error("tick off divide 1024 phase");
   // RL1 divide 128
   a_rate_128: assert property (@(posedge CLK) disable iff (SYS_RST) // RL1
      (tick && !stab_reset && ctrl.clk_sel == 2'b10) |-> div_cnt[6:0] == 7'h7F)
      else $error("tick off divide 128 phase");
   // RL10 stop gates
   a_stop_gates: assert property (@(posedge CLK) disable iff (SYS_RST) // RL10
      (STOP_ENTER && !STOP_WAKE_INT) |=> !OSC_ENABLE && !CPU_CLK_EN)
      else $error("stop did not gate oscillator and cpu clock");
   // RL10 wake restarts
   a_wake_stab: assert property (@(posedge CLK) disable iff (SYS_RST) // RL10
      (state == bwt_pkg::BWT_RUN && stopped && STOP_WAKE_INT && !STOP_ENTER) |=>
      state == bwt_pkg::BWT_STAB && OSC_ENABLE && !stab_reset)
      else $error("wake did not restart stabilization");
   // RL10 frozen in stop
   a_stop_freeze: assert property (@(posedge CLK) disable iff (SYS_RST) // RL10
      stopped |=> count == 8'h00 && div_cnt == '0)
      else $error("counter ran in stop");
   // RL7 pulse ends
   a_rst_pulse_end: assert property (@(posedge CLK) disable iff (SYS_RST) // RL7
      (state == bwt_pkg::BWT_RST && rst_cnt == 4'h1) |=> !WDT_RESET && state == bwt_pkg::BWT_RUN)
      else $error("watchdog reset pulse did not end");
   // RL5 divider steps
   a_div_step: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
      (!wr_div_clr && !stopped) |=> div_cnt == $past(div_cnt) + DIV_W'(1))
      else $error("divider cleared without a request");
   // RL5 shared clear only on request
   a_shared_clr: assert property (@(posedge CLK) disable iff (SYS_RST) // RL5
      !wr_div_clr |=> !SHARED_DIV_CLR)
      else $error("shared divider clear without a request");
endmodule : bwt_timer

// file: src/bwt_regs.svh
// register offsets, fields, reset values and timing counts for the basic watchdog timer
`ifndef BWT_REGS_SVH
`define BWT_REGS_SVH
`define BWT_CTRL_ADDR     8'hD3
`define BWT_COUNT_ADDR    8'hFD
`define BWT_CTRL_RESET    8'h00
`define BWT_WDT_OFF_CODE  4'hA
`define BWT_WDT_MSB       7
`define BWT_WDT_LSB       4
`define BWT_SEL_MSB       3
`define BWT_SEL_LSB       2
`define BWT_CNT_CLR_BIT   1
`define BWT_DIV_CLR_BIT   0
`define BWT_DIV_4096      13'h1000
`define BWT_DIV_1024      13'h0400
`define BWT_DIV_128       13'h0080
`define BWT_DIV_16        13'h0010
`define BWT_STAB_BIT      4
`define BWT_RST_PULSE     4'h8
`endif

// file: src/bwt_pkg.sv
// types for the basic watchdog timer
package bwt_pkg;
   typedef struct packed {
      logic [3:0] wdt_code;
      logic [1:0] clk_sel;
      logic       cnt_clr;
      logic       div_clr;
   } bwt_ctrl_t;
   typedef enum logic [2:0] {
      BWT_RUN  = 3'b001,
      BWT_STAB = 3'b010,
      BWT_RST  = 3'b100
   } bwt_state_t;
endpackage : bwt_pkg

// file: sim/bwt_cpu_model.sv
// cpu-side model: register bus, stop and wake lines
`timescale 1ns/1ps
module bwt_cpu_model (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic            wr,
   output logic            rd,
   output logic      [7:0] wdata,
   output logic            stop,
   output logic            wake
);
   initial
   begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      stop = 1'b0;
      wake = 1'b0;
   end
   // address is inverted once released so no stale match survives
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic pulse(input bit w);
      @(posedge clk);
      if (w)
         wake <= 1'b1;
      else
         stop <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      stop <= 1'b0;
   endtask : pulse
   task automatic kick(input int n, input int gap);
      repeat (n)
      begin
         repeat (gap) @(posedge clk);
         wr_reg(8'hD3, 8'h0E);
      end
   endtask : kick
endmodule : bwt_cpu_model

// file: sim/basic_watchdog_stabilization_timer_bench.sv
// self-checking bench for the basic watchdog timer
`timescale 1ns/1ps
module basic_watchdog_stabilization_timer_bench;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] addr, wdata, rdata, v;
   logic       wr, rd, stop, wake, osc_en, cpu_en, stab_done, wdt_rst, div_clr;
   int         errors = 0;
   int         num_checks = 0;
   int         cycles = 0;
   int         seen = 0;
   int         n;
   int         div[4] = '{4096, 1024, 128, 16};
   always #5 clk = ~clk;
   bwt_cpu_model i_cpu (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata), .stop(stop), .wake(wake));
   bwt_timer i_dut (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .STOP_ENTER(stop), .STOP_WAKE_INT(wake),
      .REG_RDATA(rdata), .OSC_ENABLE(osc_en), .CPU_CLK_EN(cpu_en),
      .STAB_DONE(stab_done), .WDT_RESET(wdt_rst), .SHARED_DIV_CLR(div_clr));
   // ceiling covers the long stabilization after reset plus all scenarios
   always @(posedge clk)
   begin
      cycles++;
      if (wdt_rst === 1'b1)
         seen++;
      if (cycles == 200000)
      begin
         errors++;
         test_done();
      end
   end
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic wait_ev(input bit w, input int lim);
      for (n = 0; n < lim; n++)
      begin
         @(posedge clk);
         #1;
         if ((w ? wdt_rst : stab_done) === 1'b1)
            break;
      end
   endtask : wait_ev
   task automatic t_reset;
      i_cpu.rd_reg(8'hD3, v);
      check(v === 8'h00 && cpu_en === 1'b0 && osc_en === 1'b1, "reset state");
      i_cpu.wr_reg(8'hFD, 8'h55);
      i_cpu.rd_reg(8'hFD, v);
      check(v < 8'h02, "count took a write");
      wait_ev(0, 32 * 4096 + 64);
      check(n > 30 * 4096 && n < 32 * 4096 + 64, "stabilization length");
      #11;
      check(cpu_en === 1'b1, "cpu clock after stabilization");
   endtask : t_reset
   task automatic t_sel;
      for (int s = 0; s < 4; s++)
      begin
         i_cpu.wr_reg(8'hD3, {4'h0, 2'(s), 2'b11});
         #1;
         check(div_clr === 1'b1, "shared divider clear");
         repeat (div[s] * 3) @(posedge clk);
         i_cpu.rd_reg(8'hFD, v);
         check(v === 8'h03 || v === 8'h02, "prescaled count");
         i_cpu.rd_reg(8'hD3, v);
         check(v === {4'h0, 2'(s), 2'b00}, "control readback");
      end
   endtask : t_sel
   task automatic t_wdt;
      i_cpu.wr_reg(8'hD3, 8'h0F);
      seen = 0;
      i_cpu.kick(4, 3000);
      check(seen == 0, "reset despite clears");
      wait_ev(1, 4200);
      check(n > 4000 && n < 4200, "overflow reset time");
      i_cpu.rd_reg(8'hFD, v);
      check(v < 8'h02, "count wrap");
      repeat (10) @(posedge clk);
      check(seen == 8, "reset pulse length");
   endtask : t_wdt
   task automatic t_off;
      i_cpu.wr_reg(8'hD3, 8'hAE);
      seen = 0;
      repeat (4200) @(posedge clk);
      check(seen == 0, "disabled watchdog reset");
      i_cpu.wr_reg(8'hD3, 8'hBE);
      wait_ev(1, 4200);
      check(n < 4200, "code 1011 keeps watchdog");
      i_cpu.wr_reg(8'hD3, 8'hAE);
      // let the reset pulse finish, a stop request during it is not taken
      repeat (12) @(posedge clk);
   endtask : t_off
   task automatic t_stop;
      i_cpu.pulse(0);
      repeat (4) @(posedge clk);
      check(cpu_en === 1'b0 && osc_en === 1'b0, "stop state");
      i_cpu.pulse(1);
      repeat (2) @(posedge clk);
      check(osc_en === 1'b1, "oscillator restart");
      wait_ev(0, 32 * 16 + 64);
      check(n > 30 * 16 && n < 32 * 16 + 64, "stabilization at preset rate");
      #11;
      check(cpu_en === 1'b1, "cpu clock after wake");
   endtask : t_stop
   task automatic test_done;
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_sel();
      t_wdt();
      t_off();
      t_stop();
      test_done();
   end
endmodule : basic_watchdog_stabilization_timer_bench
